// >>> acm_pkg.sv
package acm_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] PIN_DIRECTION_AND_MUTE_FORWARD_OFS = 8'h08;
  localparam logic [7:0] SERIAL_CLOCK_DIRECTION_POLARITY_OFS = 8'h09;
  localparam logic [7:0] MASTER_DIVIDER_RESET_CONTROL_OFS = 8'h0c;
  localparam logic [7:0] CLOCK_SOURCE_SELECT_OFS = 8'h0d;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PIN_TWO_OUTPUT_ENABLE_BIT = 5;
  localparam int MUTE_FORWARD_ENABLE_BIT = 4;
  localparam int PIN_ZERO_OUTPUT_ENABLE_BIT = 3;
  localparam int BIT_CLOCK_INVERT_BIT = 5;
  localparam int BIT_CLOCK_OUTPUT_ENABLE_BIT = 4;
  localparam int FRAME_CLOCK_OUTPUT_ENABLE_BIT = 0;
  localparam int BIT_CLOCK_DIVIDER_RUN_BIT = 1;
  localparam int FRAME_CLOCK_DIVIDER_RUN_BIT = 0;
  localparam int PLL_REFERENCE_SELECT_BIT = 4;
  localparam int DSP_CLOCK_SOURCE_LSB = 0;
  localparam int DSP_CLOCK_SOURCE_W = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic PIN_TWO_OUTPUT_ENABLE_RST = 1'b0;
  localparam logic MUTE_FORWARD_ENABLE_RST = 1'b0;
  localparam logic PIN_ZERO_OUTPUT_ENABLE_RST = 1'b0;
  localparam logic BIT_CLOCK_INVERT_RST = 1'b0;
  localparam logic BIT_CLOCK_OUTPUT_ENABLE_RST = 1'b0;
  localparam logic FRAME_CLOCK_OUTPUT_ENABLE_RST = 1'b0;
  localparam logic BIT_CLOCK_DIVIDER_RUN_RST = 1'b0;
  localparam logic FRAME_CLOCK_DIVIDER_RUN_RST = 1'b1;
  localparam logic PLL_REFERENCE_SELECT_RST = 1'b0;
  localparam logic [2:0] DSP_CLOCK_SOURCE_RST = 3'h0;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------
  // Timing and widths
  // ----------------------------------------
  localparam int MCLK_PERIOD_NS = 4;
  localparam int DIV_W = 8;

  typedef logic [DIV_W-1:0] acm_div_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acm_reg_req_t;

  typedef struct packed {
    logic i;
    logic o;
    logic oe;
  } acm_pin_t;

endpackage : acm_pkg

// >>> acm_clock_divider.sv
`timescale 1ns/10ps
module acm_clock_divider
  import acm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic tick,
  input wire acm_pkg::acm_div_t ratio,
  output logic clk_out_q
);

  // Period is ratio+1 input ticks; high for the first half
  acm_div_t cnt_q;
  acm_div_t cnt_d;

  always_comb
  begin
    cnt_d = (cnt_q >= ratio) ? '0 : acm_div_t'(cnt_q + 1'b1);
  end

  // Held in reset the output parks low at once, cutting short any high phase in progress
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      clk_out_q <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= '0;
      clk_out_q <= 1'b0;
    end
    else if (tick)
    begin
      cnt_q <= cnt_d;
      clk_out_q <= (cnt_d <= (ratio >> 1));
    end
  end

endmodule : acm_clock_divider

// >>> acm_serial_clock_ctrl.sv
`timescale 1ns/10ps
// Contract
// - Pin two is input when its enable bit is 0, driven when 1.
// - Mute request reaches the amplifier only while forwarding is enabled.
// - Pin zero is input when its enable bit is 0, driven when 1.
// - Invert 0 samples on bit clock rise; invert 1 samples on fall.
// - Bit clock output enable drives divided master clock out as master.
// - Frame clock output enable drives divided bit clock out as master.
// - Bit clock divider held in reset while its run bit is 0.
// - Frame clock divider held in reset while its run bit is 0.
// - PLL reference is master clock when select is 0, bit clock when 1.
module acm_serial_clock_ctrl
  import acm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire acm_pkg::acm_reg_req_t reg_req,
  output logic [7:0] reg_rdata_q,
  input wire acm_pkg::acm_div_t bit_clock_div_ratio,
  input wire acm_pkg::acm_div_t frame_clock_div_ratio,
  input wire logic dac_mute_req,
  output logic amp_mute_q,
  input wire logic general_pin_two_i,
  output logic general_pin_two_o,
  output logic general_pin_two_oe,
  input wire logic pin_two_drive_val,
  output logic pin_two_in_q,
  input wire logic general_pin_zero_i,
  output logic general_pin_zero_o,
  output logic general_pin_zero_oe,
  input wire logic pin_zero_drive_val,
  output logic pin_zero_in_q,
  input wire logic bit_clock_i,
  output logic bit_clock_o,
  output logic bit_clock_oe,
  input wire logic frame_clock_i,
  output logic frame_clock_o,
  output logic frame_clock_oe,
  input wire logic serial_data_i,
  output logic data_valid_q,
  output logic data_bit_q,
  output logic frame_level_q,
  output logic pll_ref_bit_clock_q,
  output logic [2:0] dsp_clock_source_q
);

  import acm_pkg::*;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic pin_two_output_enable_q;
  logic mute_forward_enable_q;
  logic pin_zero_output_enable_q;
  logic bit_clock_invert_q;
  logic bit_clock_output_enable_q;
  logic frame_clock_output_enable_q;
  logic bit_clock_divider_run_q;
  logic frame_clock_divider_run_q;
  logic pll_reference_select_q;
  logic [2:0] dsp_clock_source_select_q;

  logic wr_pin;
  logic wr_clk;
  logic wr_div;
  logic wr_src;

  assign wr_pin = reg_req.wr && (reg_req.addr == PIN_DIRECTION_AND_MUTE_FORWARD_OFS);
  assign wr_clk = reg_req.wr && (reg_req.addr == SERIAL_CLOCK_DIRECTION_POLARITY_OFS);
  assign wr_div = reg_req.wr && (reg_req.addr == MASTER_DIVIDER_RESET_CONTROL_OFS);
  assign wr_src = reg_req.wr && (reg_req.addr == CLOCK_SOURCE_SELECT_OFS);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_two_output_enable_q <= PIN_TWO_OUTPUT_ENABLE_RST;
      mute_forward_enable_q <= MUTE_FORWARD_ENABLE_RST;
      pin_zero_output_enable_q <= PIN_ZERO_OUTPUT_ENABLE_RST;
    end
    else if (wr_pin)
    begin
      pin_two_output_enable_q <= reg_req.wdata[PIN_TWO_OUTPUT_ENABLE_BIT];
      mute_forward_enable_q <= reg_req.wdata[MUTE_FORWARD_ENABLE_BIT];
      pin_zero_output_enable_q <= reg_req.wdata[PIN_ZERO_OUTPUT_ENABLE_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_clock_invert_q <= BIT_CLOCK_INVERT_RST;
      bit_clock_output_enable_q <= BIT_CLOCK_OUTPUT_ENABLE_RST;
      frame_clock_output_enable_q <= FRAME_CLOCK_OUTPUT_ENABLE_RST;
    end
    else if (wr_clk)
    begin
      bit_clock_invert_q <= reg_req.wdata[BIT_CLOCK_INVERT_BIT];
      bit_clock_output_enable_q <= reg_req.wdata[BIT_CLOCK_OUTPUT_ENABLE_BIT];
      frame_clock_output_enable_q <= reg_req.wdata[FRAME_CLOCK_OUTPUT_ENABLE_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_clock_divider_run_q <= BIT_CLOCK_DIVIDER_RUN_RST;
      frame_clock_divider_run_q <= FRAME_CLOCK_DIVIDER_RUN_RST;
    end
    else if (wr_div)
    begin
      bit_clock_divider_run_q <= reg_req.wdata[BIT_CLOCK_DIVIDER_RUN_BIT];
      frame_clock_divider_run_q <= reg_req.wdata[FRAME_CLOCK_DIVIDER_RUN_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_reference_select_q <= PLL_REFERENCE_SELECT_RST;
      dsp_clock_source_select_q <= DSP_CLOCK_SOURCE_RST;
    end
    else if (wr_src)
    begin
      pll_reference_select_q <= reg_req.wdata[PLL_REFERENCE_SELECT_BIT];
      dsp_clock_source_select_q <=
        reg_req.wdata[DSP_CLOCK_SOURCE_LSB +: DSP_CLOCK_SOURCE_W];
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Reserved bits read as zero; unmapped offsets return zero
  logic [7:0] rd_d;

  always_comb
  begin
    rd_d = READ_ZERO;
    unique case (reg_req.addr)
      PIN_DIRECTION_AND_MUTE_FORWARD_OFS:
      begin
        rd_d[PIN_TWO_OUTPUT_ENABLE_BIT] = pin_two_output_enable_q;
        rd_d[MUTE_FORWARD_ENABLE_BIT] = mute_forward_enable_q;
        rd_d[PIN_ZERO_OUTPUT_ENABLE_BIT] = pin_zero_output_enable_q;
      end
      SERIAL_CLOCK_DIRECTION_POLARITY_OFS:
      begin
        rd_d[BIT_CLOCK_INVERT_BIT] = bit_clock_invert_q;
        rd_d[BIT_CLOCK_OUTPUT_ENABLE_BIT] = bit_clock_output_enable_q;
        rd_d[FRAME_CLOCK_OUTPUT_ENABLE_BIT] = frame_clock_output_enable_q;
      end
      MASTER_DIVIDER_RESET_CONTROL_OFS:
      begin
        rd_d[BIT_CLOCK_DIVIDER_RUN_BIT] = bit_clock_divider_run_q;
        rd_d[FRAME_CLOCK_DIVIDER_RUN_BIT] = frame_clock_divider_run_q;
      end
      CLOCK_SOURCE_SELECT_OFS:
      begin
        rd_d[PLL_REFERENCE_SELECT_BIT] = pll_reference_select_q;
        rd_d[DSP_CLOCK_SOURCE_LSB +: DSP_CLOCK_SOURCE_W] = dsp_clock_source_select_q;
      end
      default:
      begin
        rd_d = READ_ZERO;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_q <= READ_ZERO;
    else if (reg_req.rd)
      reg_rdata_q <= rd_d;
  end

  // ----------------------------------------
  // General pins and mute forwarding
  // ----------------------------------------
  assign general_pin_two_oe = pin_two_output_enable_q;
  assign general_pin_zero_oe = pin_zero_output_enable_q;
  assign pll_ref_bit_clock_q = pll_reference_select_q;
  assign dsp_clock_source_q = dsp_clock_source_select_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      general_pin_two_o <= 1'b0;
      general_pin_zero_o <= 1'b0;
      pin_two_in_q <= 1'b0;
      pin_zero_in_q <= 1'b0;
      amp_mute_q <= 1'b0;
    end
    else
    begin
      general_pin_two_o <= pin_two_drive_val;
      general_pin_zero_o <= pin_zero_drive_val;
      pin_two_in_q <= general_pin_two_i;
      pin_zero_in_q <= general_pin_zero_i;
      amp_mute_q <= dac_mute_req && mute_forward_enable_q;
    end
  end

  // ----------------------------------------
  // Master-mode clock generation
  // ----------------------------------------
  logic bclk_gen;
  logic fclk_gen;
  logic bclk_gen_prev_q;
  logic bclk_gen_fall;

  assign bclk_gen_fall = bclk_gen_prev_q && !bclk_gen;

  acm_clock_divider u_bit_div
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(bit_clock_divider_run_q),
    .tick(1'b1),
    .ratio(bit_clock_div_ratio),
    .clk_out_q(bclk_gen)
  );

  // Frame divider advances on generated bit clock falls only
  acm_clock_divider u_frame_div
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(frame_clock_divider_run_q),
    .tick(bclk_gen_fall),
    .ratio(frame_clock_div_ratio),
    .clk_out_q(fclk_gen)
  );

  assign bit_clock_o = bclk_gen;
  assign bit_clock_oe = bit_clock_output_enable_q;
  assign frame_clock_o = fclk_gen;
  assign frame_clock_oe = frame_clock_output_enable_q;

  // ----------------------------------------
  // Serial data capture
  // ----------------------------------------
  // Master or slave bit clock picked per pin direction
  logic bck_cur;
  logic frame_cur;
  logic bck_prev_q;
  logic sample_edge;

  assign bck_cur = bit_clock_output_enable_q ? bclk_gen : bit_clock_i;
  assign frame_cur = frame_clock_output_enable_q ? fclk_gen : frame_clock_i;
  // Data changes on the opposite edge, so sample on the other one
  assign sample_edge = (bck_cur != bck_prev_q) && (bck_cur == !bit_clock_invert_q);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bck_prev_q <= 1'b0;
      bclk_gen_prev_q <= 1'b0;
      data_valid_q <= 1'b0;
      data_bit_q <= 1'b0;
      frame_level_q <= 1'b0;
    end
    else
    begin
      bck_prev_q <= bck_cur;
      bclk_gen_prev_q <= bclk_gen;
      data_valid_q <= sample_edge;
      if (sample_edge)
      begin
        data_bit_q <= serial_data_i;
        frame_level_q <= frame_cur;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  chk_pin_two_dir: assert property (wr_pin |=>
    general_pin_two_oe == $past(reg_req.wdata[PIN_TWO_OUTPUT_ENABLE_BIT]))
    else $error("pin two direction not taken from write");

  chk_pin_zero_dir: assert property (wr_pin |=>
    general_pin_zero_oe == $past(reg_req.wdata[PIN_ZERO_OUTPUT_ENABLE_BIT]))
    else $error("pin zero direction not taken from write");

  chk_mute_fwd_gate: assert property (!mute_forward_enable_q |=> !amp_mute_q)
    else $error("mute forwarded while disabled");

  chk_mute_fwd_pass: assert property ((mute_forward_enable_q && dac_mute_req) |=> amp_mute_q)
    else $error("mute not forwarded while enabled");

  chk_sample_edge_pol: assert property (data_valid_q |->
    ($past(bck_cur) != $past(bck_prev_q)) && ($past(bck_cur) != $past(bit_clock_invert_q)))
    else $error("data sampled on wrong bit clock edge");

  chk_bclk_held_low: assert property (!bit_clock_divider_run_q |=> !bit_clock_o)
    else $error("bit clock moves while divider held");

  chk_fclk_held_low: assert property (!frame_clock_divider_run_q |=> !frame_clock_o)
    else $error("frame clock moves while divider held");

  chk_bclk_div_two: assert property ((bit_clock_divider_run_q && bit_clock_div_ratio == 8'h01
    && $past(bit_clock_divider_run_q, 2) && $past(bit_clock_div_ratio) == 8'h01)
    |=> bit_clock_o != $past(bit_clock_o))
    else $error("bit clock divider not dividing by two");

  chk_bclk_oe_write: assert property (wr_clk |=>
    bit_clock_oe == $past(reg_req.wdata[BIT_CLOCK_OUTPUT_ENABLE_BIT]))
    else $error("bit clock direction not taken from write");

  chk_fclk_oe_write: assert property (wr_clk |=>
    frame_clock_oe == $past(reg_req.wdata[FRAME_CLOCK_OUTPUT_ENABLE_BIT]))
    else $error("frame clock direction not taken from write");

  chk_pll_ref_sel: assert property (wr_src |=>
    pll_ref_bit_clock_q == $past(reg_req.wdata[PLL_REFERENCE_SELECT_BIT]))
    else $error("pll reference select not taken from write");

  cov_master_frame: cover property (frame_clock_oe && bit_clock_oe && $rose(frame_clock_o));
  cov_slave_sample: cover property (!bit_clock_oe && data_valid_q);
  cov_mute_forward: cover property ($rose(amp_mute_q));

endmodule : acm_serial_clock_ctrl

// >>> acm_audio_source.sv
`timescale 1ns/10ps
// ----------
// Audio source
// ----------
module acm_audio_source
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic frame_on,
  input wire logic invert,
  input wire logic bck_w,
  output logic bck_drv,
  output logic lrck_drv,
  output logic sdata
);
  logic [2:0] ph_q;
  logic [4:0] cnt_q;
  logic [7:0] pat_q;
  logic bck_d1_q;
  logic launch;

  // Launch on the edge opposite the sampling one, from whoever owns the clock
  assign launch = invert ? (bck_w & ~bck_d1_q) : (~bck_w & bck_d1_q);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_q <= 3'h0;
      cnt_q <= 5'h00;
      pat_q <= 8'h96;
      bck_d1_q <= 1'b0;
      bck_drv <= 1'b0;
      lrck_drv <= 1'b0;
      sdata <= 1'b0;
    end
    else
    begin
      bck_d1_q <= bck_w;
      ph_q <= frame_on ? ph_q + 3'h1 : 3'h0;
      // Clock stands still between frames
      bck_drv <= frame_on & ph_q[2];
      if (!frame_on)
        sdata <= ~sdata;
      else if (launch)
      begin
        pat_q <= {pat_q[6:0], pat_q[7]};
        sdata <= pat_q[7];
        cnt_q <= cnt_q + 5'h01;
        lrck_drv <= cnt_q[4];
      end
    end
  end
endmodule : acm_audio_source

// >>> acm_serial_clock_ctrl_tb.sv
`timescale 1ns/10ps
module acm_serial_clock_ctrl_tb;
  import acm_pkg::*;
  // ----------
  // Register rows: write flag, offset, write data, read back
  // ----------
  localparam logic [24:0] ROWS [14] = '{25'h008_0000, 25'h009_0000, 25'h00c_0001,
    25'h00d_0000, 25'h00a_0000, 25'h108_ff38, 25'h109_ff31, 25'h10c_ff03, 25'h10d_ff17,
    25'h10a_ff00, 25'h108_0000, 25'h109_0000, 25'h10c_0000, 25'h10d_0000};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  acm_reg_req_t reg_req = '0;
  acm_div_t bit_clock_div_ratio = 8'h07;
  acm_div_t frame_clock_div_ratio = 8'h01;
  logic dac_mute_req = 1'b0;
  logic general_pin_two_i = 1'b0;
  logic pin_two_drive_val = 1'b0;
  logic general_pin_zero_i = 1'b0;
  logic pin_zero_drive_val = 1'b0;
  logic frame_on = 1'b0;
  logic invert = 1'b0;
  logic [7:0] reg_rdata_q;
  logic amp_mute_q, general_pin_two_o, general_pin_two_oe, pin_two_in_q;
  logic general_pin_zero_o, general_pin_zero_oe, pin_zero_in_q;
  logic bit_clock_i, bit_clock_o, bit_clock_oe, frame_clock_i, frame_clock_o, frame_clock_oe;
  logic serial_data_i, data_valid_q, data_bit_q, frame_level_q, pll_ref_bit_clock_q;
  logic [2:0] dsp_clock_source_q;
  logic bck_drv, lrck_drv;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  int p;

  always #2 mclk = ~mclk;

  // Clock pins resolve between the block and the source
  assign bit_clock_i = bit_clock_oe ? bit_clock_o : bck_drv;
  assign frame_clock_i = frame_clock_oe ? frame_clock_o : lrck_drv;

  acm_serial_clock_ctrl acm_serial_clock_ctrl_inst (.mclk, .rst_n, .reg_req, .reg_rdata_q,
    .bit_clock_div_ratio, .frame_clock_div_ratio, .dac_mute_req, .amp_mute_q,
    .general_pin_two_i, .general_pin_two_o, .general_pin_two_oe, .pin_two_drive_val,
    .pin_two_in_q, .general_pin_zero_i, .general_pin_zero_o, .general_pin_zero_oe,
    .pin_zero_drive_val, .pin_zero_in_q, .bit_clock_i, .bit_clock_o, .bit_clock_oe,
    .frame_clock_i, .frame_clock_o, .frame_clock_oe, .serial_data_i, .data_valid_q,
    .data_bit_q, .frame_level_q, .pll_ref_bit_clock_q, .dsp_clock_source_q);

  acm_audio_source acm_audio_source_inst (.mclk(mclk), .rst_n(rst_n), .frame_on(frame_on),
    .invert(invert), .bck_w(bit_clock_i), .bck_drv(bck_drv), .lrck_drv(lrck_drv),
    .sdata(serial_data_i));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_req = '{wr: w, rd: ~w, addr: a, wdata: d};
    @(negedge mclk);
    reg_req = '0;
  endtask : access

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(1'b1, a, d);
    @(negedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    access(1'b0, a, 8'h00);
    @(negedge mclk);
    check(reg_rdata_q, e);
  endtask : rd

  // Every sampled bit must match what stood on the line
  task automatic stream(input int cyc);
    n = 0;
    repeat (cyc)
    begin
      @(negedge mclk);
      if (data_valid_q === 1'b1)
      begin
        n++;
        check(data_bit_q, serial_data_i);
        check(frame_level_q, frame_clock_i);
      end
    end
  endtask : stream

  // Cycles between two rising edges; -1 when the clock never rises
  task automatic period(input logic sel);
    logic prev;
    logic cur;
    prev = 1'b1;
    p = -1;
    for (int k = 0; k < 300; k++)
    begin
      @(negedge mclk);
      cur = sel ? frame_clock_o : bit_clock_o;
      if (cur && !prev && p >= 0)
        break;
      if (cur && !prev)
        p = 0;
      if (p >= 0)
        p++;
      prev = cur;
    end
  endtask : period

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    foreach (ROWS[i])
    begin
      if (ROWS[i][24])
        access(1'b1, ROWS[i][23:16], ROWS[i][15:8]);
      rd(ROWS[i][23:16], ROWS[i][7:0]);
    end
    $display("test register map done");
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h08, {2'b00, k[1], 1'b0, k[0], 3'b000});
      pin_two_drive_val = k[0];
      pin_zero_drive_val = !k[0];
      general_pin_two_i = !k[1];
      general_pin_zero_i = k[0];
      repeat (2) @(negedge mclk);
      check(general_pin_two_oe, k[1]);
      check(general_pin_zero_oe, k[0]);
      check(general_pin_two_o, k[0]);
      check(general_pin_zero_o, !k[0]);
      check(pin_two_in_q, !k[1]);
      check(pin_zero_in_q, k[0]);
    end
    $display("test pin direction done");
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h08, k[0] ? 8'h10 : 8'h00);
      dac_mute_req = 1'b1;
      repeat (2) @(negedge mclk);
      check(amp_mute_q, k[0]);
      dac_mute_req = 1'b0;
      repeat (2) @(negedge mclk);
      check(amp_mute_q, 8'h00);
    end
    $display("test mute forward done");
    for (int k = 0; k < 2; k++)
    begin
      invert = k[0];
      wr(8'h09, k[0] ? 8'h20 : 8'h00);
      frame_on = 1'b1;
      stream(200);
      check(8'(n >= 24 && n <= 26), 8'h01);
      frame_on = 1'b0;
      repeat (4) @(negedge mclk);
      stream(40);
      check(8'(n), 8'h00);
    end
    $display("test slave sampling done");
    invert = 1'b0;
    wr(8'h0c, 8'h03);
    wr(8'h09, 8'h11);
    frame_on = 1'b1;
    check(bit_clock_oe, 8'h01);
    check(frame_clock_oe, 8'h01);
    period(1'b0);
    check(8'(p), bit_clock_div_ratio + 8'h01);
    period(1'b1);
    check(8'(p), (frame_clock_div_ratio + 8'h01) * (bit_clock_div_ratio + 8'h01));
    stream(200);
    check(8'(n >= 24 && n <= 26), 8'h01);
    bit_clock_div_ratio = 8'h01;
    period(1'b0);
    check(8'(p), 8'h02);
    bit_clock_div_ratio = 8'h07;
    $display("test master clocks done");
    wr(8'h0c, 8'h02);
    period(1'b1);
    check(8'(p), 8'hff);
    check(frame_clock_o, 8'h00);
    wr(8'h0c, 8'h01);
    period(1'b0);
    check(8'(p), 8'hff);
    check(bit_clock_o, 8'h00);
    wr(8'h0c, 8'h00);
    frame_on = 1'b0;
    $display("test divider hold done");
    wr(8'h0d, 8'h15);
    check(pll_ref_bit_clock_q, 8'h01);
    check(dsp_clock_source_q, 8'h05);
    wr(8'h0d, 8'h02);
    check(pll_ref_bit_clock_q, 8'h00);
    check(dsp_clock_source_q, 8'h02);
    $display("test clock source done");
    wr(8'h0c, 8'h02);
    wr(8'h08, 8'h28);
    rst_n = 1'b0;
    @(negedge mclk);
    check(general_pin_two_oe, 8'h00);
    rst_n = 1'b1;
    rd(8'h0c, 8'h01);
    rd(8'h08, 8'h00);
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule : acm_serial_clock_ctrl_tb
